// ### lpm_cfg.svh
// constants for the low-power mode controller: register offset, field positions, reset values, timing
// assumes a plain register port with byte-wide data and a 40 MHz system clock
// ==========================================================================
// Overview of operation
// [RULE1] stop instruction enters stop; all but brown-out, amplifier, watchdog powered down
// [RULE2] stop halts crystal oscillator, precision oscillator and system clock
// [RULE3] stop disables crystal interface; its two pins return to port control
// [RULE4] stop and halt both freeze the cpu and hold the program counter
// [RULE5] stop keeps watchdog oscillator if enabled, and watchdog logic if enabled
// [RULE6] stop keeps brown-out circuit only when the option bit allows it
// [RULE7] stop keeps the amplifier running while its disable bit is clear
// [RULE8] stop idles every other peripheral
// [RULE9] halt stops only the cpu; oscillator and system clock keep running
// [RULE10] halt keeps watchdog oscillator, watchdog and enabled peripherals running
// [RULE11] halt ends on interrupt, watchdog timeout, power-on, brown-out or pin reset
// [RULE12] stop ends only through stop-mode recovery
// [RULE13] neither stop nor halt means active; peripherals may still be disabled
// [RULE14] each set disable bit gates the clock or removes power of its block
// [RULE15] amplifier disable resets to one; writing zero keeps it on even in stop
// [RULE16] disable register is reset only by power-on reset
// [RULE17] brown-out active only when its disable bit is clear and option bit set
// [RULE18] bits 3,2,1 disable temperature sensor, converter, comparator; one means off
// [RULE19] software writes zeros to reserved bits 6:5 and 0
// [RULE20] a set disable bit wins over the block's own enable bits
// [RULE21] software should set amplifier disable before stop if not needed
// [RULE22] an enabled recovery pin starts recovery on either edge
// [RULE23] leaving stop restarts oscillators and waits for clock before fetching
// [RULE24] leaving halt by interrupt resumes at the held program counter after service
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

`define LPM_PWR_DIS_ADDR 12'hf80
`define LPM_PWR_DIS_RESET 8'h80
`define LPM_BIT_AMP 7
`define LPM_BIT_BROWNOUT 4
`define LPM_BIT_TEMP 3
`define LPM_BIT_ADC 2
`define LPM_BIT_COMP 1
`define LPM_RESERVED_MASK 8'h61
`define LPM_MODE_ADDR 12'hf81
`define LPM_OSC_SETTLE_NS 1000
`define LPM_CLK_PERIOD_NS 25

`endif

// ### lpm_cpu_model.sv
// cpu core stand-in: turns one-cycle bench requests into stop and halt instruction pulses
// assumes requests last one cycle and the controller reports whether the core runs
`timescale 1ns/1ps
`default_nettype none
module lpm_cpu_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cpu_run,
  input wire logic req_stop,
  input wire logic req_halt,
  output logic stop_instr,
  output logic halt_instr
);
  // ==========================================================================
  // instruction issue
  // a frozen core fetches nothing, so no instruction issues while cpu_run is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stop_instr <= 1'b0;
      halt_instr <= 1'b0;
    end else begin
      stop_instr <= req_stop & cpu_run;
      halt_instr <= req_halt & cpu_run;
    end
  end
endmodule : lpm_cpu_model
`default_nettype wire

// ### lpm_ctrl.sv
// low-power mode controller: stop/halt sequencing, clock and oscillator gating, peripheral disables
// assumes cpu pulses stop_instr/halt_instr for one cycle; sys_clk is the free-running reference
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int PIN_COUNT = 8,
  parameter int SETTLE_NS = `LPM_OSC_SETTLE_NS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic stop_instr,
  input wire logic halt_instr,
  input wire logic irq_pending,
  input wire logic watchdog_timeout,
  input wire logic brownout_reset,
  input wire logic ext_reset,
  input wire logic watchdog_enable,
  input wire logic watchdog_osc_enable,
  input wire logic brownout_always_on_option,
  input wire logic brownout_stop_option,
  input wire logic crystal_enable,
  input wire logic [PIN_COUNT-1:0] recovery_pin,
  input wire logic [PIN_COUNT-1:0] recovery_pin_enable,
  output logic cpu_run,
  output logic pc_hold,
  output logic crystal_osc_run,
  output logic precision_osc_run,
  output logic sys_clk_gate,
  output logic crystal_pins_owned,
  output logic watchdog_osc_run,
  output logic watchdog_run,
  output logic brownout_active,
  output logic lowpower_amp_on,
  output logic temp_sensor_on,
  output logic adc_on,
  output logic comparator_on,
  output logic periph_clk_run,
  output logic stop_recovered
);
  // ==========================================================================
  // timing
  localparam int SETTLE_CYC_RAW = (SETTLE_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam int CW = $clog2(SETTLE_CYC + 1);

  // ==========================================================================
  // state
  lpm_state_t state;
  lpm_state_t next_state;
  logic [7:0] peripheral_power_disable;
  logic [CW-1:0] settle_cnt;
  logic wake_pin;
  logic halt_exit;
  logic stop_exit;
  logic settled;

  lpm_wake_edge #(
    .WIDTH(PIN_COUNT)
  ) u_wake (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .arm(state == LPM_STOP),
    .pin_in(recovery_pin),
    .pin_enable(recovery_pin_enable),
    .wake(wake_pin)
  );

  // ==========================================================================
  // mode sequencing
  // resets end halt through rst_n too; listed here so halt releases even before reset lands
  assign halt_exit = irq_pending | watchdog_timeout | brownout_reset | ext_reset; // [RULE11]
  // only the recovery mechanism may leave stop: pin edge or watchdog timeout
  assign stop_exit = wake_pin | (watchdog_timeout & watchdog_run); // [RULE12]
  assign settled = (settle_cnt == CW'(SETTLE_CYC));

  always_comb begin
    next_state = state;
    unique case (state)
      LPM_ACTIVE: begin
        if (stop_instr) begin
          next_state = LPM_STOP; // [RULE1]
        end else if (halt_instr) begin
          next_state = LPM_HALT; // [RULE9]
        end
      end
      LPM_HALT: begin
        if (halt_exit) begin
          next_state = LPM_ACTIVE; // [RULE24]
        end
      end
      LPM_STOP: begin
        if (stop_exit) begin
          next_state = LPM_WAKE; // [RULE12]
        end
      end
      LPM_WAKE: begin
        if (settled) begin
          next_state = LPM_ACTIVE; // [RULE23]
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= LPM_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // settle counter runs on the free reference while the gated clock is held off
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state != LPM_WAKE) begin
      settle_cnt <= '0;
    end else if (!settled) begin
      settle_cnt <= settle_cnt + CW'(1); // [RULE23]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stop_recovered <= 1'b0;
    end else begin
      stop_recovered <= (state == LPM_WAKE) && settled;
    end
  end

  // ==========================================================================
  // peripheral disable register, loaded with its reset value only by power-on reset
  logic hit_pwr;
  logic hit_mode;
  logic [7:0] pwr_wdata;
  assign hit_pwr = (reg_addr == `LPM_PWR_DIS_ADDR);
  assign hit_mode = (reg_addr == `LPM_MODE_ADDR);
  // reserved bits are held at zero whatever software writes
  assign pwr_wdata = reg_wdata & ~`LPM_RESERVED_MASK; // [RULE19]

  always_ff @(posedge sys_clk) begin
    if (!por_n) begin
      peripheral_power_disable <= `LPM_PWR_DIS_RESET; // [RULE16] [RULE15]
    end else if (reg_write && hit_pwr) begin
      peripheral_power_disable <= pwr_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read && hit_pwr) begin
      reg_rdata <= peripheral_power_disable;
    end else if (reg_read && hit_mode) begin
      reg_rdata <= {6'h00, state};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // gating outputs
  logic in_stop;
  logic in_halt;
  logic clk_live;
  assign in_stop = (state == LPM_STOP) || (state == LPM_WAKE);
  assign in_halt = (state == LPM_HALT);
  assign clk_live = !in_stop; // [RULE13]

  assign cpu_run = !in_stop && !in_halt; // [RULE4]
  assign pc_hold = in_stop || in_halt; // [RULE4]
  // oscillators restart during the wake settle window, clock gate opens after
  assign crystal_osc_run = (state != LPM_STOP) && crystal_enable; // [RULE2] [RULE23]
  assign precision_osc_run = (state != LPM_STOP); // [RULE2]
  assign sys_clk_gate = clk_live; // [RULE2] [RULE9]
  assign crystal_pins_owned = crystal_enable && !in_stop; // [RULE3]
  assign watchdog_osc_run = in_stop ? watchdog_osc_enable : 1'b1; // [RULE5] [RULE10]
  assign watchdog_run = watchdog_enable; // [RULE5] [RULE10]
  assign brownout_active = !peripheral_power_disable[`LPM_BIT_BROWNOUT] && brownout_always_on_option
                           && (!in_stop || brownout_stop_option); // [RULE17] [RULE6]
  assign lowpower_amp_on = !peripheral_power_disable[`LPM_BIT_AMP]; // [RULE7] [RULE15] [RULE20]
  assign temp_sensor_on = clk_live && !peripheral_power_disable[`LPM_BIT_TEMP]; // [RULE18] [RULE8]
  assign adc_on = clk_live && !peripheral_power_disable[`LPM_BIT_ADC]; // [RULE18] [RULE8]
  assign comparator_on = clk_live && !peripheral_power_disable[`LPM_BIT_COMP]; // [RULE18] [RULE14]
  assign periph_clk_run = clk_live; // [RULE8] [RULE10]

  // ==========================================================================
  // checks
  a_stop_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == LPM_ACTIVE && stop_instr) |=> (state == LPM_STOP && !sys_clk_gate)) // [RULE1]
    else $error("stop instruction did not enter stop");
  a_halt_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == LPM_HALT) |-> (sys_clk_gate && !cpu_run && pc_hold)) // [RULE9]
    else $error("halt gated the clock or ran the cpu");
  a_stop_osc_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == LPM_STOP) |-> (!crystal_osc_run && !precision_osc_run && !crystal_pins_owned)) // [RULE2]
    else $error("oscillator left running in stop");
  a_halt_exit_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == LPM_HALT && irq_pending) |=> (state == LPM_ACTIVE && cpu_run)) // [RULE11]
    else $error("interrupt did not end halt");
  a_stop_stays: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == LPM_STOP && !stop_exit) |=> (state == LPM_STOP)) // [RULE12]
    else $error("stop left without recovery");
  a_wake_settle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(state == LPM_WAKE)) |-> (!cpu_run)[*2]) // [RULE23]
    else $error("cpu resumed before clock settled");
  a_amp_reg: assert property (@(posedge sys_clk) disable iff (!por_n)
    (reg_write && hit_pwr) |=> (lowpower_amp_on == !$past(reg_wdata[7]))) // [RULE15]
    else $error("amplifier did not follow its disable bit");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!por_n)
    (peripheral_power_disable & `LPM_RESERVED_MASK) == 8'h00) // [RULE19]
    else $error("reserved bits set");
  a_adc_disable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    peripheral_power_disable[`LPM_BIT_ADC] |-> !adc_on) // [RULE20]
    else $error("disabled converter still on");
endmodule : lpm_ctrl
`default_nettype wire

// ### lpm_pkg.sv
// types for the low-power mode controller
// shared by the controller and its testbench
`default_nettype none
package lpm_pkg;
  typedef enum logic [1:0] {
    LPM_ACTIVE = 2'b00,
    LPM_HALT = 2'b01,
    LPM_STOP = 2'b11,
    LPM_WAKE = 2'b10
  } lpm_state_t;
endpackage : lpm_pkg
`default_nettype wire

// ### lpm_tb.sv
// self-checking bench for the low-power mode controller
// assumes lpm_pkg, lpm_ctrl and lpm_cpu_model compiled first; settle shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module testbench;
  import lpm_pkg::*;
  localparam logic [11:0] PD = `LPM_PWR_DIS_ADDR;
  localparam logic [11:0] MD = `LPM_MODE_ADDR;
  logic sys_clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic req_stop = 1'b0, req_halt = 1'b0, stop_instr, halt_instr;
  logic irq_pending = 1'b0, watchdog_timeout = 1'b0, brownout_reset = 1'b0, ext_reset = 1'b0;
  logic watchdog_enable = 1'b1, watchdog_osc_enable = 1'b1, brownout_always_on_option = 1'b1;
  logic brownout_stop_option = 1'b0, crystal_enable = 1'b1;
  logic [7:0] recovery_pin = 8'h00, recovery_pin_enable = 8'h01;
  logic cpu_run, pc_hold, crystal_osc_run, precision_osc_run, sys_clk_gate, crystal_pins_owned;
  logic watchdog_osc_run, watchdog_run, brownout_active, lowpower_amp_on, temp_sensor_on, adc_on;
  logic comparator_on, periph_clk_run, stop_recovered;
  int n_errors = 0, cmp_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  lpm_cpu_model cpu (.sys_clk, .rst_n, .cpu_run, .req_stop, .req_halt, .stop_instr, .halt_instr);
  lpm_ctrl #(.PIN_COUNT(8), .SETTLE_NS(100)) dut (.sys_clk, .rst_n, .por_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .stop_instr, .halt_instr, .irq_pending, .watchdog_timeout,
    .brownout_reset, .ext_reset, .watchdog_enable, .watchdog_osc_enable, .brownout_always_on_option,
    .brownout_stop_option, .crystal_enable, .recovery_pin, .recovery_pin_enable, .cpu_run, .pc_hold,
    .crystal_osc_run, .precision_osc_run, .sys_clk_gate, .crystal_pins_owned, .watchdog_osc_run,
    .watchdog_run, .brownout_active, .lowpower_amp_on, .temp_sensor_on, .adc_on, .comparator_on,
    .periph_clk_run, .stop_recovered);
  // ==========================================================================
  // bus and sequencing helpers
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic issue(input logic stop);
    @(posedge sys_clk);
    req_stop <= stop;
    req_halt <= ~stop;
    @(posedge sys_clk);
    req_stop <= 1'b0;
    req_halt <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : issue
  // waits for cpu_run (sel 0) or the recovery pulse (sel 1); a hang ends the run
  task automatic wait_sig(input bit sel);
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      #1;
      if ((sel ? stop_recovered : cpu_run) === 1'b1) return;
    end
    n_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    stop_test();
  endtask : wait_sig
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] d;
    rd(PD, d);
    `CHK(d, `LPM_PWR_DIS_RESET)
    `CHK({lowpower_amp_on, brownout_active, temp_sensor_on, adc_on, comparator_on, cpu_run}, 6'h1f)
    wr(PD, 8'h1e); // reserved bits kept zero
    rd(PD, d);
    `CHK(d, 8'h1e)
    `CHK({brownout_active, temp_sensor_on, adc_on, comparator_on}, 4'h0)
    wr(PD, 8'h00);
    `CHK(lowpower_amp_on, 1'b1)
    @(posedge sys_clk) brownout_always_on_option <= 1'b0;
    #1;
    `CHK(brownout_active, 1'b0)
    @(posedge sys_clk) brownout_always_on_option <= 1'b1;
    rd(12'h123, d);
    `CHK(d, 8'h00)
    $display("test regs done");
  endtask : t_regs
  task automatic t_halt;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      issue(1'b0);
      `CHK({cpu_run, pc_hold, sys_clk_gate, crystal_osc_run, watchdog_osc_run}, 5'h0f)
      `CHK({watchdog_run, periph_clk_run, lowpower_amp_on}, 3'h7)
      rd(MD, d);
      `CHK(d, {6'h00, LPM_HALT})
      @(posedge sys_clk) {irq_pending, watchdog_timeout, brownout_reset, ext_reset} <= 4'h8 >> i;
      wait_sig(1'b0);
      @(posedge sys_clk) {irq_pending, watchdog_timeout, brownout_reset, ext_reset} <= 4'h0;
    end
    $display("test halt done");
  endtask : t_halt
  task automatic t_stop(input logic amp_off, input logic lvl);
    logic [7:0] d;
    wr(PD, {amp_off, 7'h00}); // amplifier off when not needed in stop
    @(posedge sys_clk) brownout_stop_option <= amp_off;
    issue(1'b1);
    `CHK({cpu_run, pc_hold, crystal_osc_run, precision_osc_run, sys_clk_gate}, 5'h08)
    `CHK(crystal_pins_owned, 1'b0)
    `CHK({watchdog_osc_run, watchdog_run}, 2'h3)
    `CHK({brownout_active, lowpower_amp_on}, {amp_off, ~amp_off})
    `CHK({temp_sensor_on, adc_on, comparator_on, periph_clk_run}, 4'h0)
    @(posedge sys_clk) recovery_pin[1] <= ~recovery_pin[1];
    irq_pending <= 1'b1;
    rd(MD, d);
    `CHK(d, {6'h00, LPM_STOP})
    irq_pending <= 1'b0;
    @(posedge sys_clk) recovery_pin[0] <= lvl;
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    `CHK({cpu_run, crystal_osc_run}, 2'h1)
    wait_sig(1'b1);
    @(posedge sys_clk);
    #1;
    `CHK(cpu_run, 1'b1)
    $display("test stop done");
  endtask : t_stop
  // watchdog timeout is the other recovery source; it needs the watchdog enabled
  task automatic t_stop_wdt;
    issue(1'b1);
    `CHK(cpu_run, 1'b0)
    @(posedge sys_clk) watchdog_timeout <= 1'b1;
    @(posedge sys_clk) watchdog_timeout <= 1'b0;
    wait_sig(1'b1);
    @(posedge sys_clk);
    #1;
    `CHK(cpu_run, 1'b1)
    $display("test stop watchdog done");
  endtask : t_stop_wdt
  task automatic t_resets;
    logic [7:0] d;
    wr(PD, 8'h1e);
    @(posedge sys_clk) rst_n <= 1'b0;
    @(posedge sys_clk) rst_n <= 1'b1;
    rd(PD, d);
    `CHK(d, 8'h1e)
    @(posedge sys_clk) por_n <= 1'b0;
    @(posedge sys_clk) por_n <= 1'b1;
    rd(PD, d);
    `CHK(d, `LPM_PWR_DIS_RESET)
    $display("test resets done");
  endtask : t_resets
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_regs();
    t_halt();
    t_stop(1'b0, 1'b1);
    t_stop(1'b1, 1'b0);
    t_stop_wdt();
    t_resets();
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// ### lpm_wake_edge.sv
// recovery pin edge detector: flags a change in either direction on enabled pins
// assumes pins already synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_edge #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] pin_enable,
  output logic wake
);
  logic [WIDTH-1:0] pin_prev;
  logic [WIDTH-1:0] pin_change;

  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_pin
    assign pin_change[i] = pin_enable[i] & (pin_in[i] ^ pin_prev[i]); // [RULE22]
  end

  assign wake = arm & (|pin_change);

  // prev tracks the pin at all times so entering stop does not fake an edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_in;
    end
  end

  a_wake_on_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (arm && (pin_enable & (pin_in ^ $past(pin_in))) != '0) |-> wake) // [RULE22]
    else $error("enabled pin edge did not raise wake");
endmodule : lpm_wake_edge
`default_nettype wire
